/* File: hdl/cts_pkg.sv */
// Purpose: shared constants for the change threshold send trigger block
// Assumes: 200 MHz reference clock, 32-bit register port with byte addresses
// Notes:   offsets are byte addresses of aligned words
package cts_pkg;

  // clock and calculation cycle timing
  localparam int unsigned CTS_CLK_MHZ       = 200;
  localparam int unsigned CTS_CALC_MS       = 500;
  localparam int unsigned CTS_CALC_CYCLES   = CTS_CALC_MS * CTS_CLK_MHZ * 1000;
  localparam int unsigned CTS_TICKS_PER_SEC = 2;

  // integration formula constants
  localparam logic [31:0] CTS_DEV_SCALE = 32'h0000_000a;
  localparam logic [14:0] CTS_THR_MAX   = 15'h7fff;

  // time scheme unit multipliers in seconds
  localparam logic [11:0] CTS_MUL_SEC  = 12'h001;
  localparam logic [11:0] CTS_MUL_MIN  = 12'h03c;
  localparam logic [11:0] CTS_MUL_HOUR = 12'he10;

  // wall clock wrap values
  localparam logic [4:0] CTS_HOUR_LAST = 5'h17;
  localparam logic [5:0] CTS_MIN_LAST  = 6'h3b;
  localparam logic [5:0] CTS_SEC_LAST  = 6'h3b;

  // register offsets
  localparam logic [7:0] CTS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CTS_OFF_THRESH = 8'h04;
  localparam logic [7:0] CTS_OFF_TOD    = 8'h08;
  localparam logic [7:0] CTS_OFF_SCHEME = 8'h0c;
  localparam logic [7:0] CTS_OFF_EXTADR = 8'h10;
  localparam logic [7:0] CTS_OFF_ACC    = 8'h14;
  localparam logic [7:0] CTS_OFF_STATUS = 8'h18;
  localparam logic [7:0] CTS_OFF_TIME   = 8'h1c;

  // control register field positions
  localparam int CTS_CTRL_TIME_EN  = 0;
  localparam int CTS_CTRL_SCHEME   = 1;
  localparam int CTS_CTRL_EXT_EN   = 2;
  localparam int CTS_CTRL_AREA_LO  = 3;

  // reset values
  localparam logic [14:0] CTS_THRESH_RST = 15'h0000;
  localparam logic [15:0] CTS_SCH_CNT_RST = 16'h0000;

  // trigger bit memory area
  typedef enum logic [1:0] {
    CTS_AREA_DATA_BLOCK = 2'b00,
    CTS_AREA_MEMORY_BIT = 2'b01,
    CTS_AREA_INPUT_IMG  = 2'b10
  } cts_area_t;

  // time scheme unit
  typedef enum logic [1:0] {
    CTS_UNIT_SEC  = 2'b00,
    CTS_UNIT_MIN  = 2'b01,
    CTS_UNIT_HOUR = 2'b10
  } cts_unit_t;

  // cause of the last transfer
  typedef enum logic [2:0] {
    CTS_CAUSE_NONE = 3'b000,
    CTS_CAUSE_THR  = 3'b001,
    CTS_CAUSE_TIME = 3'b010,
    CTS_CAUSE_EXT  = 3'b100
  } cts_cause_t;

endpackage : cts_pkg

/* File: hdl/cts_timebase.sv */
// Purpose: free running time base with calculation tick and wall clock
// Assumes: ref_clk at 200 MHz, software may load the wall clock
// Notes:   ticks are one-cycle pulses that coincide with the updated time
`timescale 1ns/100ps
module cts_timebase
  import cts_pkg::*;
#(
  parameter int unsigned CALC_CYCLES = cts_pkg::CTS_CALC_CYCLES
)(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       time_set,
  input  wire logic [4:0] set_hour,
  input  wire logic [5:0] set_min,
  input  wire logic [5:0] set_sec,
  output logic            calc_tick,
  output logic            sec_tick,
  output logic [4:0]      hour,
  output logic [5:0]      minute,
  output logic [5:0]      second
);

  // the divider needs at least two states per tick
  if (CALC_CYCLES < 2)
  begin : g_bad_calc
    $error("cts_timebase: unsupported CALC_CYCLES");
  end

  logic [31:0] div_q,  div_d;
  logic        half_q, half_d;
  logic        calc_q, calc_d;
  logic        sec_q,  sec_d;
  logic [4:0]  hr_q,   hr_d;
  logic [5:0]  mn_q,   mn_d;
  logic [5:0]  sc_q,   sc_d;

  // divider and wall clock next state
  always_comb
  begin
    div_d  = div_q + 32'h0000_0001;
    half_d = half_q;
    calc_d = 1'b0;
    sec_d  = 1'b0;
    hr_d   = hr_q;
    mn_d   = mn_q;
    sc_d   = sc_q;
    if (div_q == 32'(CALC_CYCLES - 1))
    begin
      div_d  = 32'h0000_0000;
      calc_d = 1'b1;
      half_d = ~half_q;
      if (half_q)
      begin
        sec_d = 1'b1;
        sc_d  = (sc_q == CTS_SEC_LAST) ? 6'h00 : sc_q + 6'h01;
        if (sc_q == CTS_SEC_LAST)
        begin
          mn_d = (mn_q == CTS_MIN_LAST) ? 6'h00 : mn_q + 6'h01;
          if (mn_q == CTS_MIN_LAST)
            hr_d = (hr_q == CTS_HOUR_LAST) ? 5'h00 : hr_q + 5'h01;
        end
      end
    end
    // a load wins over the running count
    if (time_set)
    begin
      hr_d = set_hour;
      mn_d = set_min;
      sc_d = set_sec;
    end
  end

  // register the time base
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      div_q  <= 32'h0000_0000;
      half_q <= 1'b0;
      calc_q <= 1'b0;
      sec_q  <= 1'b0;
      hr_q   <= 5'h00;
      mn_q   <= 6'h00;
      sc_q   <= 6'h00;
    end
    else
    begin
      div_q  <= div_d;
      half_q <= half_d;
      calc_q <= calc_d;
      sec_q  <= sec_d;
      hr_q   <= hr_d;
      mn_q   <= mn_d;
      sc_q   <= sc_d;
    end
  end

  assign calc_tick = calc_q;
  assign sec_tick  = sec_q;
  assign hour      = hr_q;
  assign minute    = mn_q;
  assign second    = sc_q;

endmodule : cts_timebase

/* File: hdl/cts_send_trigger.sv */
// Purpose: send trigger of one data object: change threshold, time and external bit
// Assumes: process values and trigger byte are scanned from controller memory
// Notes:   a transfer snapshots every channel of the object into the send buffer
`timescale 1ns/100ps
module cts_send_trigger
  import cts_pkg::*;
#(
  parameter int unsigned NCH         = 4,
  parameter int unsigned DW          = 16,
  parameter int unsigned CALC_CYCLES = cts_pkg::CTS_CALC_CYCLES
)(
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  input  wire logic [NCH*DW-1:0]   proc_values,
  input  wire logic                scan_tick,
  input  wire logic [7:0]          trig_byte_in,
  output cts_pkg::cts_area_t       trig_area,
  output logic [15:0]              trig_block_no,
  output logic [11:0]              trig_byte_no,
  output logic                     trig_clr,
  output logic [2:0]               trig_clr_bit,
  output logic                     xfer,
  output logic [NCH*DW-1:0]        send_data
);
  import cts_pkg::*;

  // refuse shapes the logic cannot serve
  if (NCH < 1 || DW < 2 || DW > 16 || CALC_CYCLES < 2)
  begin : g_bad_param
    $error("cts_send_trigger: unsupported parameter values");
  end

  logic        calc_tick;
  logic        sec_tick;
  logic [4:0]  hour;
  logic [5:0]  minute;
  logic [5:0]  second;
  logic        time_set;

  // configuration state
  logic        time_en_q,  time_en_d;
  logic        scheme_q,   scheme_d;
  logic        ext_en_q,   ext_en_d;
  cts_area_t   area_q,     area_d;
  logic [14:0] thr_q,      thr_d;
  logic        tod_ok_q,   tod_ok_d;
  logic [4:0]  tod_hr_q,   tod_hr_d;
  logic [5:0]  tod_mn_q,   tod_mn_d;
  logic [15:0] sch_cnt_q,  sch_cnt_d;
  cts_unit_t   sch_unit_q, sch_unit_d;
  logic [15:0] blk_q,      blk_d;
  logic [11:0] byte_q,     byte_d;
  logic [2:0]  bit_q,      bit_d;
  logic        cfg_wr;

  // trigger core state
  logic [31:0]       acc_q,    acc_d;
  logic [27:0]       sec_ctr_q, sec_ctr_d;
  logic              ext_prev_q, ext_prev_d;
  logic              xfer_q,   xfer_d;
  logic              clr_q,    clr_d;
  logic [NCH*DW-1:0] sbuf_q,   sbuf_d;
  cts_cause_t        cause_q,  cause_d;
  logic [31:0]       rdata_q,  rdata_d;

  // combinational trigger terms
  logic [DW-1:0] pv0;
  logic [DW-1:0] ref0;
  logic [31:0]   dev;
  logic [31:0]   den;
  logic [31:0]   step;
  logic [31:0]   acc_sum;
  logic [27:0]   interval;
  logic          thr_fire;
  logic          tod_fire;
  logic          sch_fire;
  logic          time_fire;
  logic          ext_bit;
  logic          ext_fire;
  logic          any_fire;

  // scheme unit to seconds, used only for the interval
  function automatic logic [11:0] unit_mul(input cts_unit_t u);
    case (u)
      CTS_UNIT_MIN:  unit_mul = CTS_MUL_MIN;
      CTS_UNIT_HOUR: unit_mul = CTS_MUL_HOUR;
      default:       unit_mul = CTS_MUL_SEC;
    endcase
  endfunction : unit_mul

  cts_timebase #(
    .CALC_CYCLES (CALC_CYCLES)
  ) u_timebase (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .time_set  (time_set),
    .set_hour  (reg_wdata[20:16]),
    .set_min   (reg_wdata[13:8]),
    .set_sec   (reg_wdata[5:0]),
    .calc_tick (calc_tick),
    .sec_tick  (sec_tick),
    .hour      (hour),
    .minute    (minute),
    .second    (second)
  );

  assign time_set = reg_wr && (reg_addr == CTS_OFF_TIME);
  assign cfg_wr   = reg_wr && (reg_addr == CTS_OFF_CTRL || reg_addr == CTS_OFF_TOD ||
                               reg_addr == CTS_OFF_SCHEME);

  // register writes; reserved bits are dropped
  always_comb
  begin
    time_en_d  = time_en_q;
    scheme_d   = scheme_q;
    ext_en_d   = ext_en_q;
    area_d     = area_q;
    thr_d      = thr_q;
    tod_ok_d   = tod_ok_q;
    tod_hr_d   = tod_hr_q;
    tod_mn_d   = tod_mn_q;
    sch_cnt_d  = sch_cnt_q;
    sch_unit_d = sch_unit_q;
    blk_d      = blk_q;
    byte_d     = byte_q;
    bit_d      = bit_q;
    if (reg_wr && reg_addr == CTS_OFF_CTRL)
    begin
      // one mode bit keeps the alternatives exclusive
      time_en_d = reg_wdata[CTS_CTRL_TIME_EN];
      scheme_d  = reg_wdata[CTS_CTRL_SCHEME];
      ext_en_d  = reg_wdata[CTS_CTRL_EXT_EN];
      area_d    = (reg_wdata[CTS_CTRL_AREA_LO +: 2] == 2'b11) ? CTS_AREA_DATA_BLOCK
                                                               : cts_area_t'(reg_wdata[CTS_CTRL_AREA_LO +: 2]);
      // moving to scheme forgets the time of day
      if (reg_wdata[CTS_CTRL_SCHEME] && !scheme_q)
      begin
        tod_ok_d = 1'b0;
        tod_hr_d = 5'h00;
        tod_mn_d = 6'h00;
      end
    end
    else if (reg_wr && reg_addr == CTS_OFF_THRESH)
      // values above 32767 cannot be held
      thr_d = reg_wdata[14:0] & CTS_THR_MAX;
    else if (reg_wr && reg_addr == CTS_OFF_TOD)
    begin
      tod_ok_d = 1'b1;
      tod_hr_d = reg_wdata[12:8];
      tod_mn_d = reg_wdata[5:0];
    end
    else if (reg_wr && reg_addr == CTS_OFF_SCHEME)
    begin
      sch_cnt_d  = reg_wdata[15:0];
      sch_unit_d = (reg_wdata[17:16] == 2'b11) ? CTS_UNIT_SEC : cts_unit_t'(reg_wdata[17:16]);
    end
    else if (reg_wr && reg_addr == CTS_OFF_EXTADR)
    begin
      // block number, byte and bit of the trigger signal
      blk_d  = reg_wdata[15:0];
      byte_d = reg_wdata[27:16];
      bit_d  = reg_wdata[30:28];
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      time_en_q  <= 1'b0;
      scheme_q   <= 1'b0;
      ext_en_q   <= 1'b0;
      area_q     <= CTS_AREA_DATA_BLOCK;
      thr_q      <= CTS_THRESH_RST;
      tod_ok_q   <= 1'b0;
      tod_hr_q   <= 5'h00;
      tod_mn_q   <= 6'h00;
      sch_cnt_q  <= CTS_SCH_CNT_RST;
      sch_unit_q <= CTS_UNIT_SEC;
      blk_q      <= 16'h0000;
      byte_q     <= 12'h000;
      bit_q      <= 3'h0;
    end
    else
    begin
      time_en_q  <= time_en_d;
      scheme_q   <= scheme_d;
      ext_en_q   <= ext_en_d;
      area_q     <= area_d;
      thr_q      <= thr_d;
      tod_ok_q   <= tod_ok_d;
      tod_hr_q   <= tod_hr_d;
      tod_mn_q   <= tod_mn_d;
      sch_cnt_q  <= sch_cnt_d;
      sch_unit_q <= sch_unit_d;
      blk_q      <= blk_d;
      byte_q     <= byte_d;
      bit_q      <= bit_d;
    end
  end

  // deviation against the stored send buffer value, not the last sample
  assign pv0  = proc_values[DW-1:0];
  assign ref0 = sbuf_q[DW-1:0];
  assign dev  = (pv0 >= ref0) ? 32'(pv0 - ref0) : 32'(ref0 - pv0);

  // divider only sees a nonzero threshold; zero is gated below anyway
  assign den     = (dev * CTS_DEV_SCALE) / ((thr_q == 15'h0000) ? 32'h1 : 32'(thr_q)) + 32'h1;
  assign step    = dev / den;
  assign acc_sum = acc_q + step;

  // integration only on the 500 ms calculation tick
  // zero threshold disables the change trigger
  assign thr_fire = calc_tick && (thr_q != 15'h0000) && (acc_sum >= 32'(thr_q));

  // fire once at second zero of the matching minute
  assign tod_fire = !scheme_q && tod_ok_q && sec_tick && second == 6'h00 &&
                    hour == tod_hr_q && minute == tod_mn_q;
  // interval in seconds from count and unit
  assign interval = 28'(sch_cnt_q) * 28'(unit_mul(sch_unit_q)); // widened first so hours cannot wrap
  assign sch_fire = scheme_q && sec_tick && interval != 28'h0 && (sec_ctr_q + 28'h1 >= interval);
  // nothing from the clock unless the time trigger is active
  assign time_fire = time_en_q && (tod_fire || sch_fire);

  // rising edge of the scanned trigger bit
  assign ext_bit  = trig_byte_in[bit_q];
  assign ext_fire = ext_en_q && scan_tick && ext_bit && !ext_prev_q;

  assign any_fire = thr_fire || time_fire || ext_fire;

  // trigger core next state
  always_comb
  begin
    acc_d      = acc_q;
    sec_ctr_d  = sec_ctr_q;
    ext_prev_d = ext_prev_q;
    xfer_d     = any_fire;
    clr_d      = 1'b0;
    sbuf_d     = sbuf_q;
    cause_d    = cause_q;
    if (calc_tick)
      // threshold store restarts integration from the new reference
      acc_d = thr_fire ? 32'h0000_0000 : ((thr_q == 15'h0000) ? 32'h0000_0000 : acc_sum);
    // scheme counter restarts on any control, time of day or scheme write; a wall clock load leaves it running
    if (cfg_wr || !scheme_q || !time_en_q)
      sec_ctr_d = 28'h0;
    else if (sec_tick)
      sec_ctr_d = sch_fire ? 28'h0 : sec_ctr_q + 28'h1;
    if (scan_tick && ext_en_q)
    begin
      ext_prev_d = ext_bit;
      // memory and data block bits are reset after reading a one
      clr_d = ext_bit && (area_q != CTS_AREA_INPUT_IMG);
      // cleared bit reads back as zero next scan, so no edge is missed
      if (clr_d)
        ext_prev_d = 1'b0;
    end
    // every channel of the object is captured together
    // the present value becomes the stored reference
    if (any_fire)
    begin
      sbuf_d  = proc_values;
      cause_d = cts_cause_t'({ext_fire, time_fire, thr_fire});
    end
  end

  // trigger core registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      acc_q      <= 32'h0000_0000;
      sec_ctr_q  <= 28'h0;
      ext_prev_q <= 1'b0;
      xfer_q     <= 1'b0;
      clr_q      <= 1'b0;
      sbuf_q     <= '0;
      cause_q    <= CTS_CAUSE_NONE;
    end
    else
    begin
      acc_q      <= acc_d;
      sec_ctr_q  <= sec_ctr_d;
      ext_prev_q <= ext_prev_d;
      xfer_q     <= xfer_d;
      clr_q      <= clr_d;
      sbuf_q     <= sbuf_d;
      cause_q    <= cause_d;
    end
  end

  // read mux; unmapped offsets and reserved bits read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (!reg_rd)
      rdata_d = 32'h0000_0000;
    else if (reg_addr == CTS_OFF_CTRL)
      rdata_d = {27'h0, area_q, ext_en_q, scheme_q, time_en_q};
    else if (reg_addr == CTS_OFF_THRESH)
      rdata_d = {17'h0, thr_q};
    else if (reg_addr == CTS_OFF_TOD)
      rdata_d = {tod_ok_q, 18'h0, tod_hr_q, 2'h0, tod_mn_q};
    else if (reg_addr == CTS_OFF_SCHEME)
      rdata_d = {14'h0, sch_unit_q, sch_cnt_q};
    else if (reg_addr == CTS_OFF_EXTADR)
      rdata_d = {1'b0, bit_q, byte_q, blk_q};
    else if (reg_addr == CTS_OFF_ACC)
      rdata_d = acc_q;
    else if (reg_addr == CTS_OFF_STATUS)
      rdata_d = {13'h0, cause_q, 16'(ref0)};
    else if (reg_addr == CTS_OFF_TIME)
      rdata_d = {11'h0, hour, 2'h0, minute, 2'h0, second};
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata     = rdata_q;
  assign trig_area     = area_q;
  assign trig_block_no = blk_q;
  assign trig_byte_no  = byte_q;
  assign trig_clr      = clr_q;
  assign trig_clr_bit  = bit_q;
  assign xfer          = xfer_q;
  assign send_data     = sbuf_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  calc_only_a: assert property (!calc_tick |=> $stable(acc_q))
    else $error("integral moved outside calculation tick");
  accum_step_a: assert property (calc_tick && thr_q != 15'h0 && !thr_fire |=> acc_q == $past(acc_q) + $past(step))
    else $error("integral step wrong");
  ref_store_a: assert property (thr_fire |=> xfer_q && sbuf_q[DW-1:0] == $past(pv0))
    else $error("threshold fire did not store present value");
  dev_ref_a: assert property (!any_fire |=> $stable(sbuf_q))
    else $error("reference moved without a transfer");
  acc_clear_a: assert property (thr_fire |=> acc_q == 32'h0)
    else $error("integral not cleared after store");
  thr_zero_a: assert property (thr_q == 15'h0 && calc_tick |-> !thr_fire ##1 acc_q == 32'h0)
    else $error("zero threshold still integrates");
  time_off_a: assert property (!time_en_q |-> !time_fire)
    else $error("time trigger fired while inactive");
  tod_drop_a: assert property (reg_wr && reg_addr == CTS_OFF_CTRL && reg_wdata[CTS_CTRL_SCHEME] && !scheme_q
                               |=> !tod_ok_q && tod_hr_q == 5'h0 && tod_mn_q == 6'h0)
    else $error("time of day kept after scheme switch");
  ext_edge_a: assert property (ext_fire |-> $past(ext_prev_d) == 1'b0 ##1 xfer_q && cause_q[2])
    else $error("external fire without rising edge");
  ext_clear_a: assert property (ext_fire && area_q != CTS_AREA_INPUT_IMG |=> trig_clr)
    else $error("trigger bit not cleared");
  all_chan_a: assert property (any_fire |=> send_data == $past(proc_values))
    else $error("object channels not all transferred");
  or_sources_a: assert property ((time_fire || ext_fire) |=> xfer_q && (cause_q[1] || cause_q[2]))
    else $error("source did not start transfer");

  thr_fire_c:  cover property (thr_fire ##1 xfer_q);
  sch_fire_c:  cover property (sch_fire && time_fire);
  ext_clear_c: cover property (ext_fire ##1 trig_clr);

endmodule : cts_send_trigger

/* File: dv/cts_mem_model.sv */
// Purpose: controller memory model holding the trigger byte
// Assumes: one byte location, scanned every third cycle
// Notes:   between scans the byte lines show the inverse of the memory
`timescale 1ns/100ps
module cts_mem_model
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] mem_set,
  input  wire logic       trig_clr,
  input  wire logic [2:0] trig_clr_bit,
  output logic            scan_tick,
  output logic [7:0]      trig_byte_in
);
  logic [7:0] mem_q;
  logic [7:0] mem_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // next memory contents and scan phase
  always_comb
  begin
    mem_d = mem_q | mem_set;
    if (trig_clr)
      mem_d[trig_clr_bit] = 1'b0;
    cnt_d = (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
  end

  // registers only
  always_ff @(posedge ref_clk)
  begin
    mem_q <= sys_rst ? 8'h00 : mem_d;
    cnt_q <= sys_rst ? 2'h0 : cnt_d;
  end

  // inverse outside scans so a stale byte is never mistaken for valid
  assign scan_tick    = (cnt_q == 2'h0);
  assign trig_byte_in = scan_tick ? mem_q : ~mem_q;
endmodule : cts_mem_model

/* File: dv/tb_top.sv */
// Purpose: self-checking bench of the send trigger block
// Assumes: calculation cycle shortened to 10 clocks
// Notes:   all expectations worked out from the trigger rules
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import cts_pkg::*;
  localparam int unsigned CALC = 10;
  logic               ref_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_rdata;
  logic [63:0]        proc_values = 64'h0;
  logic               scan_tick;
  logic [7:0]         trig_byte_in;
  cts_area_t          trig_area;
  logic [15:0]        trig_block_no;
  logic [11:0]        trig_byte_no;
  logic               trig_clr;
  logic [2:0]         trig_clr_bit;
  logic               xfer;
  logic [63:0]        send_data;
  logic [7:0]         mem_set = 8'h00;
  logic [31:0]        rd_val;
  logic [31:0]        acc0;
  logic               clr_seen;
  logic [2:0]         bit_seen;
  logic [63:0]        data_seen;
  int                 n_seen;
  int                 err_total = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  int                 step_t[2] = '{40, 32767};

  cts_send_trigger #(.CALC_CYCLES(CALC)) u_cts_send_trigger (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .proc_values(proc_values), .scan_tick(scan_tick), .trig_byte_in(trig_byte_in), .trig_area(trig_area),
    .trig_block_no(trig_block_no), .trig_byte_no(trig_byte_no), .trig_clr(trig_clr),
    .trig_clr_bit(trig_clr_bit), .xfer(xfer), .send_data(send_data));

  cts_mem_model u_cts_mem_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .mem_set(mem_set),
    .trig_clr(trig_clr), .trig_clr_bit(trig_clr_bit), .scan_tick(scan_tick), .trig_byte_in(trig_byte_in));

  // clock and hang guard
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic int step(input int d, input int t);
    return d / (((d * 10) / t) + 1);
  endfunction : step

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    // taken at the next edge, before the data fall back to zero
    @(posedge ref_clk);
    rd_val = reg_rdata;
  endtask : rd

  task automatic wait_xfer(input int lim);
    n_seen = 0;
    do
    begin
      @(posedge ref_clk);
      n_seen++;
    end while (xfer !== 1'b1 && n_seen < lim);
    clr_seen  = trig_clr;
    bit_seen  = trig_clr_bit;
    data_seen = send_data;
    `CHK("xfer", 1'b1, xfer)
  endtask : wait_xfer

  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      if (xfer !== 1'b0)
        hits++;
    end
    `CHK("quiet", 0, hits)
  endtask : quiet

  task automatic pulse_mem(input logic [7:0] m);
    @(posedge ref_clk);
    mem_set <= m;
    @(posedge ref_clk);
    mem_set <= 8'h00;
  endtask : pulse_mem

  task automatic t_reset;
    rd(CTS_OFF_THRESH);
    `CHK("thresh rst", 32'h0, rd_val)
    rd(8'h20);
    `CHK("unmapped", 32'h0, rd_val)
    #5 `CHK("rdata idle", 32'h0, reg_rdata)
    `CHK("send rst", 64'h0, send_data)
  endtask : t_reset

  task automatic t_thresh;
    proc_values <= 64'h4444_3333_2222_0002;
    wr(CTS_OFF_THRESH, 32'd12);
    wait_xfer(140);
    `CHK("fire time", 1'b1, n_seen >= 105 && n_seen <= 125)
    `CHK("all channels", 64'h4444_3333_2222_0002, data_seen)
    rd(CTS_OFF_ACC);
    `CHK("acc cleared", 32'h0, rd_val)
    rd(CTS_OFF_STATUS);
    `CHK("stored ref", 16'h0002, rd_val[15:0])
    `CHK("cause thr", 3'b001, rd_val[18:16])
    proc_values <= 64'h4444_3333_2222_0066;
    // reads ten cycles apart straddle exactly one tick
    foreach (step_t[i])
    begin
      wr(CTS_OFF_THRESH, step_t[i]);
      rd(CTS_OFF_ACC);
      acc0 = rd_val;
      repeat (7) @(posedge ref_clk);
      rd(CTS_OFF_ACC);
      `CHK("acc step", 32'(step(100, step_t[i])), rd_val - acc0)
    end
    wr(CTS_OFF_THRESH, 32'h0);
    quiet(40);
    rd(CTS_OFF_ACC);
    `CHK("acc held", 32'h0, rd_val)
  endtask : t_thresh

  task automatic t_ext;
    wr(CTS_OFF_EXTADR, 32'h3005_0007);
    wr(CTS_OFF_CTRL, 32'h0000_000c);
    // area register settles at the write edge
    @(posedge ref_clk);
    `CHK("area mem", CTS_AREA_MEMORY_BIT, trig_area)
    `CHK("byte no", 12'h005, trig_byte_no)
    `CHK("block no", 16'h0007, trig_block_no)
    pulse_mem(8'h08);
    wait_xfer(20);
    `CHK("clr mem", 1'b1, clr_seen)
    `CHK("clr bit", 3'h3, bit_seen)
    quiet(30);
    wr(CTS_OFF_CTRL, 32'h0000_0014);
    @(posedge ref_clk);
    `CHK("area img", CTS_AREA_INPUT_IMG, trig_area)
    pulse_mem(8'h08);
    wait_xfer(20);
    `CHK("no clr img", 1'b0, clr_seen)
    quiet(30);
    rd(CTS_OFF_STATUS);
    `CHK("cause ext", 3'b100, rd_val[18:16])
    wr(CTS_OFF_CTRL, 32'h0);
  endtask : t_ext

  task automatic t_time;
    // arm first, load the clock last so the minute cannot roll over unarmed
    wr(CTS_OFF_TOD, 32'h0000_0103);
    wr(CTS_OFF_CTRL, 32'h0000_0001);
    wr(CTS_OFF_TIME, 32'h0001_023b);
    wait_xfer(60);
    rd(CTS_OFF_STATUS);
    `CHK("cause time", 3'b010, rd_val[18:16])
    wr(CTS_OFF_CTRL, 32'h0000_0003);
    rd(CTS_OFF_TOD);
    `CHK("tod dropped", 32'h0, rd_val)
    wr(CTS_OFF_SCHEME, 32'h0000_0001);
    wait_xfer(40);
    wait_xfer(40);
    `CHK("period", 2 * CALC, n_seen)
    wr(CTS_OFF_CTRL, 32'h0000_0002);
    quiet(60);
  endtask : t_time

  // main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_thresh();
    t_ext();
    t_time();
    tally_and_finish();
  end
endmodule : tb_top
